//--- src/ers_pkg.sv
// ers_pkg: constants, field positions and carrier types of the e1 receive status page
// assumes: one 100 MHz system clock, host reads over an 8-bit parallel status port
package ers_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS      = 10;
  localparam int MS_NS              = 1_000_000;
  localparam int CYCLES_PER_MS      = MS_NS / CLK_PERIOD_NS;
  localparam int HALF_SEC_MS        = 500;
  localparam int CRC_SHORT_MS       = 8;
  localparam int CRC_LONG_MS        = 400;
  localparam int RED_MS             = 100;
  localparam int NONNORMAL_MS       = 100;
  localparam int TERM_LOCK_MS       = 10;
  localparam int KEEPALIVE_MS       = 100;
  localparam int MS_TIMER_W         = 9;
  // ==========================================================
  // register offsets
  localparam logic [4:0] OFS_SYNC_STATUS  = 5'h10;
  localparam logic [4:0] OFS_FAS_BITS     = 5'h11;
  localparam logic [4:0] OFS_TIMER_STATUS = 5'h12;
  localparam logic [4:0] OFS_NON_ALIGN    = 5'h13;
  localparam logic [4:0] OFS_MF_ALIGN     = 5'h14;
  localparam logic [4:0] OFS_PHASE_HIGH   = 5'h15;
  localparam logic [4:0] OFS_PHASE_LOW    = 5'h16;
  localparam logic [4:0] OFS_DEJITTER     = 5'h17;
  localparam logic [4:0] OFS_SIGNAL_LEVEL = 5'h18;
  localparam logic [4:0] OFS_ALARM_ONE    = 5'h19;
  localparam logic [4:0] OFS_SA_CHANGE    = 5'h1a;
  localparam logic [4:0] OFS_PART_ID      = 5'h1f;
  // arbitrary value, not tied to any real part
  localparam logic [7:0] PART_ID_VALUE    = 8'h5c;
  localparam logic [7:0] READ_ZERO        = 8'h00;
  localparam logic [7:0] FAS_GOOD_PATTERN = 8'h1b;
  // ==========================================================
  // field positions, shared by the sync and timer words
  localparam int BIT_BASIC_LOSS  = 7;
  localparam int BIT_MF_LOSS     = 6;
  localparam int BIT_CRC_LOSS    = 5;
  localparam int BIT_EBIT_ONE    = 4;
  localparam int BIT_EBIT_TWO    = 3;
  localparam int BIT_REFRAME     = 2;
  localparam int BIT_RED         = 1;
  localparam int BIT_INTERWORK   = 0;
  localparam int BIT_HALF_SEC    = 7;
  localparam int BIT_ONE_SEC     = 6;
  localparam int BIT_NONNORMAL   = 5;
  localparam int BIT_TERM_LOCK   = 4;
  localparam int BIT_LONG_TMR    = 3;
  localparam int BIT_SHORT_TMR   = 2;
  localparam int BIT_MS_TICK     = 1;
  localparam int BIT_KEEPALIVE   = 0;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic [7:0] non_align;
    logic [7:0] mf_align;
    logic [7:0] phase_high;
    logic [7:0] phase_low;
    logic [7:0] dejitter;
    logic [7:0] signal_level;
    logic [7:0] alarm_one;
    logic [7:0] sa_change;
  } ers_ext_status_t;

  typedef struct packed {
    logic cs;
    logic rd;
    logic [4:0] addr;
  } ers_host_req_t;
endpackage

//--- src/ers_status_bank.sv
// ers_status_bank: receive status page (offsets 10h..1fh) of an e1 framer
// assumes: framer inputs are synchronous to clk_sys; host reads over a parallel port
// Overview of operation
// - basic frame loss bit, one lost
// - signalling multiframe loss bit, one lost
// - crc-4 multiframe loss bit, one lost
// - hold both e bits each multiframe
// - reframe flag if no crc in 8ms
// - red alarm after 100ms basic loss
// - report crc interworking status bit
// - fas first bit into bit 7
// - fas bits two..eight into bits 6..0
// - half second toggle every 0.5 s
// - one second toggle, in phase
// - nonnormal persist set 100ms, cleared by lock
// - terminal lock set 10ms, cleared nonnormal
// - toggle on 400ms timer expiry
// - toggle on 8ms timer expiry
// - ms tick toggle, synced to crc
// - keepalive after 100ms ais, clears instantly
`timescale 1ns/100ps

// ==========================================================
// persistence timer: counts ms ticks while run, saturates at limit
module ers_ms_timer #(
  parameter logic [8:0] LIMIT = 9'h001
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic ms_tick,
  input  wire logic run,
  output logic      done
);
  logic [8:0] cnt_q;
  logic [8:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (!run)
      cnt_d = 9'h000;
    else if (ms_tick && cnt_q != LIMIT)
      cnt_d = cnt_q + 9'h001;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      cnt_q <= 9'h000;
    else
      cnt_q <= cnt_d;
  end

  // done drops in the very cycle run falls, so alarms clear with no stale cycle
  assign done = run && (cnt_q == LIMIT);
endmodule

// ==========================================================
module ers_status_bank #(
  parameter int CYCLES_PER_MS = ers_pkg::CYCLES_PER_MS
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic                     basic_align_loss,
  input  wire logic                     multiframe_align_loss,
  input  wire logic                     crc_multiframe_align_loss,
  input  wire logic                     multiframe_end,
  input  wire logic                     rx_ebit_one,
  input  wire logic                     rx_ebit_two,
  input  wire logic                     crc_interwork_in,
  input  wire logic                     maint_option,
  input  wire logic                     auto_interwork,
  input  wire logic                     fas_strobe,
  input  wire logic [7:0]               fas_byte,
  input  wire logic                     crc_sync_pulse,
  input  wire logic                     nonnormal_frames,
  input  wire logic                     terminal_frame_sync,
  input  wire logic                     ais_status,
  input  wire ers_pkg::ers_ext_status_t ext_status,
  input  wire ers_pkg::ers_host_req_t   host_req,
  output logic [7:0]                    host_rdata,
  output logic                          force_reframe
);
  // ==========================================================
  // millisecond prescaler
  logic [16:0] pre_q;
  logic [16:0] pre_d;
  logic        ms_tick;
  logic [16:0] pre_last;

  assign pre_last = 17'(CYCLES_PER_MS - 1);
  assign ms_tick  = (pre_q == pre_last);

  always_comb
  begin
    pre_d = ms_tick ? 17'h0_0000 : pre_q + 17'h0_0001;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      pre_q <= 17'h0_0000;
    else
      pre_q <= pre_d;
  end

  // ==========================================================
  // persistence and alignment timers
  logic red_done;
  logic nonnormal_done;
  logic lock_done;
  logic keepalive_done;
  logic short_done;
  logic long_done;

  ers_ms_timer #(.LIMIT(9'(ers_pkg::RED_MS))) u_red (
    .clk_sys (clk_sys), .rst_n (rst_n), .ms_tick (ms_tick),
    .run (basic_align_loss), .done (red_done));
  ers_ms_timer #(.LIMIT(9'(ers_pkg::NONNORMAL_MS))) u_nonnormal (
    .clk_sys (clk_sys), .rst_n (rst_n), .ms_tick (ms_tick),
    .run (nonnormal_frames), .done (nonnormal_done));
  ers_ms_timer #(.LIMIT(9'(ers_pkg::TERM_LOCK_MS))) u_lock (
    .clk_sys (clk_sys), .rst_n (rst_n), .ms_tick (ms_tick),
    .run (terminal_frame_sync), .done (lock_done));
  ers_ms_timer #(.LIMIT(9'(ers_pkg::KEEPALIVE_MS))) u_keepalive (
    .clk_sys (clk_sys), .rst_n (rst_n), .ms_tick (ms_tick),
    .run (ais_status), .done (keepalive_done));
  // 8 ms crc search timer, restarted by each basic realignment
  ers_ms_timer #(.LIMIT(9'(ers_pkg::CRC_SHORT_MS))) u_short (
    .clk_sys (clk_sys), .rst_n (rst_n), .ms_tick (ms_tick),
    .run (!basic_align_loss), .done (short_done));
  ers_ms_timer #(.LIMIT(9'(ers_pkg::CRC_LONG_MS))) u_long (
    .clk_sys (clk_sys), .rst_n (rst_n), .ms_tick (ms_tick),
    .run (!basic_align_loss), .done (long_done));

  // ==========================================================
  // status state
  logic       short_prev_q, short_prev_d;
  logic       long_prev_q, long_prev_d;
  logic       lock_prev_q, lock_prev_d;
  logic       nonn_prev_q, nonn_prev_d;
  logic       reframe_q, reframe_d;
  logic       nonnormal_q, nonnormal_d;
  logic       lock_q, lock_d;
  logic       short_tgl_q, short_tgl_d;
  logic       long_tgl_q, long_tgl_d;
  logic       ebit_one_q, ebit_one_d;
  logic       ebit_two_q, ebit_two_d;
  logic [7:0] fas_q, fas_d;
  logic       short_expire;
  logic       lock_rise;

  assign short_expire = short_done && !short_prev_q;
  assign lock_rise    = lock_q && !lock_prev_q;

  always_comb
  begin
    short_prev_d = short_done;
    long_prev_d  = long_done;
    lock_prev_d  = lock_q;
    nonn_prev_d  = nonnormal_done;
    reframe_d    = reframe_q;
    nonnormal_d  = nonnormal_q;
    lock_d       = lock_q;
    short_tgl_d  = short_tgl_q;
    long_tgl_d   = long_tgl_q;
    ebit_one_d   = ebit_one_q;
    ebit_two_d   = ebit_two_q;
    fas_d        = fas_q;
    // crc found or basic lost clears; expiry without crc sets and wins
    if (!crc_multiframe_align_loss || basic_align_loss)
      reframe_d = 1'b0;
    if (short_expire && crc_multiframe_align_loss)
      reframe_d = 1'b1;
    if (short_expire)
      short_tgl_d = !short_tgl_q;
    if (long_done && !long_prev_q)
      long_tgl_d = !long_tgl_q;
    // cleared when lock rises, a fresh 100 ms expiry wins
    if (lock_rise)
      nonnormal_d = 1'b0;
    if (nonnormal_done && !nonn_prev_q)
      nonnormal_d = 1'b1;
    // cleared by nonnormal frames, set wins on coincidence
    if (nonnormal_frames)
      lock_d = 1'b0;
    if (lock_done)
      lock_d = 1'b1;
    // e bits of the last multiframe
    if (multiframe_end)
    begin
      ebit_one_d = rx_ebit_one;
      ebit_two_d = rx_ebit_two;
    end
    // first received bit sits in fas_byte[7]
    if (fas_strobe)
      fas_d = fas_byte;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      short_prev_q <= 1'b0;
      long_prev_q  <= 1'b0;
      lock_prev_q  <= 1'b0;
      nonn_prev_q  <= 1'b0;
      reframe_q    <= 1'b0;
      nonnormal_q  <= 1'b0;
      lock_q       <= 1'b0;
      short_tgl_q  <= 1'b0;
      long_tgl_q   <= 1'b0;
      ebit_one_q   <= 1'b0;
      ebit_two_q   <= 1'b0;
      fas_q        <= ers_pkg::READ_ZERO;
    end
    else
    begin
      short_prev_q <= short_prev_d;
      long_prev_q  <= long_prev_d;
      lock_prev_q  <= lock_prev_d;
      nonn_prev_q  <= nonn_prev_d;
      reframe_q    <= reframe_d;
      nonnormal_q  <= nonnormal_d;
      lock_q       <= lock_d;
      short_tgl_q  <= short_tgl_d;
      long_tgl_q   <= long_tgl_d;
      ebit_one_q   <= ebit_one_d;
      ebit_two_q   <= ebit_two_d;
      fas_q        <= fas_d;
    end
  end

  // forced reframe only in maintenance mode without auto interworking
  assign force_reframe = reframe_q && maint_option && !auto_interwork;

  // ==========================================================
  // free running toggles
  logic [8:0]  half_cnt_q, half_cnt_d;
  logic        half_q, half_d;
  logic        one_q, one_d;
  logic [16:0] crc_align_ms_tick_cnt_q, crc_align_ms_tick_cnt_d;
  logic        crc_align_ms_tick_q, crc_align_ms_tick_d;
  logic        crc_align_ms_tick_wrap;

  assign crc_align_ms_tick_wrap = (crc_align_ms_tick_cnt_q == pre_last);

  always_comb
  begin
    half_cnt_d = half_cnt_q;
    half_d     = half_q;
    one_d      = one_q;
    crc_align_ms_tick_cnt_d = crc_align_ms_tick_wrap ? 17'h0_0000 : crc_align_ms_tick_cnt_q + 17'h0_0001;
    crc_align_ms_tick_d     = crc_align_ms_tick_q;
    if (ms_tick)
    begin
      if (half_cnt_q == 9'(ers_pkg::HALF_SEC_MS - 1))
      begin
        half_cnt_d = 9'h000;
        half_d     = !half_q;
        // one second toggle flips on every second half toggle
        if (half_q)
          one_d = !one_q;
      end
      else
        half_cnt_d = half_cnt_q + 9'h001;
    end
    // once crc aligned, the sync pulse restarts the ms phase
    if (crc_sync_pulse && !crc_multiframe_align_loss)
    begin
      crc_align_ms_tick_cnt_d = 17'h0_0000;
      crc_align_ms_tick_d     = !crc_align_ms_tick_q;
    end
    else if (crc_align_ms_tick_wrap)
      crc_align_ms_tick_d = !crc_align_ms_tick_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      half_cnt_q <= 9'h000;
      half_q     <= 1'b0;
      one_q      <= 1'b0;
      crc_align_ms_tick_cnt_q <= 17'h0_0000;
      crc_align_ms_tick_q     <= 1'b0;
    end
    else
    begin
      half_cnt_q <= half_cnt_d;
      half_q     <= half_d;
      one_q      <= one_d;
      crc_align_ms_tick_cnt_q <= crc_align_ms_tick_cnt_d;
      crc_align_ms_tick_q     <= crc_align_ms_tick_d;
    end
  end

  // ==========================================================
  // status words and host read port
  logic [7:0] sync_word;
  logic [7:0] timer_word;
  logic [7:0] rdata_q, rdata_d;

  always_comb
  begin
    sync_word[ers_pkg::BIT_BASIC_LOSS] = basic_align_loss;
    sync_word[ers_pkg::BIT_MF_LOSS]    = multiframe_align_loss;
    sync_word[ers_pkg::BIT_CRC_LOSS]   = crc_multiframe_align_loss;
    sync_word[ers_pkg::BIT_EBIT_ONE]   = ebit_one_q;
    sync_word[ers_pkg::BIT_EBIT_TWO]   = ebit_two_q;
    sync_word[ers_pkg::BIT_REFRAME]    = reframe_q;
    // red follows the persistence timer, drops on acquisition
    sync_word[ers_pkg::BIT_RED]        = red_done;
    sync_word[ers_pkg::BIT_INTERWORK]  = crc_interwork_in;
    timer_word[ers_pkg::BIT_HALF_SEC]  = half_q;
    timer_word[ers_pkg::BIT_ONE_SEC]   = one_q;
    timer_word[ers_pkg::BIT_NONNORMAL] = nonnormal_q;
    timer_word[ers_pkg::BIT_TERM_LOCK] = lock_q;
    timer_word[ers_pkg::BIT_LONG_TMR]  = long_tgl_q;
    timer_word[ers_pkg::BIT_SHORT_TMR] = short_tgl_q;
    timer_word[ers_pkg::BIT_MS_TICK]   = crc_align_ms_tick_q;
    // keepalive drops with ais since the timer clears at once
    timer_word[ers_pkg::BIT_KEEPALIVE] = keepalive_done;
  end

  always_comb
  begin
    rdata_d = rdata_q;
    // read only decode, unused offsets answer zero
    if (host_req.cs && host_req.rd)
    begin
      unique case (host_req.addr)
        ers_pkg::OFS_SYNC_STATUS:  rdata_d = sync_word;
        ers_pkg::OFS_FAS_BITS:     rdata_d = fas_q;
        ers_pkg::OFS_TIMER_STATUS: rdata_d = timer_word;
        ers_pkg::OFS_NON_ALIGN:    rdata_d = ext_status.non_align;
        ers_pkg::OFS_MF_ALIGN:     rdata_d = ext_status.mf_align;
        ers_pkg::OFS_PHASE_HIGH:   rdata_d = ext_status.phase_high;
        ers_pkg::OFS_PHASE_LOW:    rdata_d = ext_status.phase_low;
        ers_pkg::OFS_DEJITTER:     rdata_d = ext_status.dejitter;
        ers_pkg::OFS_SIGNAL_LEVEL: rdata_d = ext_status.signal_level;
        ers_pkg::OFS_ALARM_ONE:    rdata_d = ext_status.alarm_one;
        ers_pkg::OFS_SA_CHANGE:    rdata_d = ext_status.sa_change;
        ers_pkg::OFS_PART_ID:      rdata_d = ers_pkg::PART_ID_VALUE;
        default:                   rdata_d = ers_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      rdata_q <= ers_pkg::READ_ZERO;
    else
      rdata_q <= rdata_d;
  end

  assign host_rdata = rdata_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_read_at(logic [4:0] a);
    host_req.cs && host_req.rd && host_req.addr == a;
  endsequence

  AST_SYNC_READ: assert property (s_read_at(ers_pkg::OFS_SYNC_STATUS) |=>
    host_rdata[ers_pkg::BIT_BASIC_LOSS] == $past(basic_align_loss))
    else $error("basic loss bit read wrong");
  AST_EBIT_HOLD: assert property (multiframe_end |=>
    ebit_one_q == $past(rx_ebit_one) && ebit_two_q == $past(rx_ebit_two))
    else $error("e bits not captured");
  AST_REFRAME_SET: assert property (short_expire && crc_multiframe_align_loss
    |=> reframe_q) else $error("reframe flag not set");
  AST_RED_CLEAR: assert property ($fell(basic_align_loss) |-> !red_done)
    else $error("red did not clear");
  AST_FAS_READ: assert property (fas_strobe ##1 !fas_strobe ##1
    s_read_at(ers_pkg::OFS_FAS_BITS) |=> host_rdata == $past(fas_byte, 3))
    else $error("fas word wrong");
  AST_HALF_PHASE: assert property ($changed(one_q) |-> $fell(half_q))
    else $error("one second toggle out of phase");
  AST_LOCK_CLEARS_NN: assert property (lock_rise && !(nonnormal_done && !nonn_prev_q)
    |=> !nonnormal_q) else $error("nonnormal flag not cleared");
  AST_NN_CLEARS_LOCK: assert property (nonnormal_frames && !lock_done |=> !lock_q)
    else $error("lock flag not cleared");
  AST_KEEPALIVE_DROP: assert property ($fell(ais_status) |->
    !timer_word[ers_pkg::BIT_KEEPALIVE]) else $error("keepalive stayed high");
  AST_UNUSED_ZERO: assert property (s_read_at(5'h1b) |=> host_rdata == 8'h00)
    else $error("unused offset not zero");
  AST_PART_ID: assert property (s_read_at(ers_pkg::OFS_PART_ID) |=>
    host_rdata == ers_pkg::PART_ID_VALUE) else $error("identification wrong");
endmodule

//--- verif/ers_host_model.sv
// ers_host_model: host processor that reads the e1 receive status page
// assumes: requests launched on the falling edge, read data registered by the page
`timescale 1ns/100ps

module ers_host_model (
  input  wire logic              clk_sys,
  output ers_pkg::ers_host_req_t host_req,
  input  wire logic [7:0]        host_rdata
);
  initial
  begin
    host_req = '{cs: 1'b0, rd: 1'b0, addr: 5'h0a};
  end

  // ==========================================================
  // one byte read: request held across the taking edge, data taken once it stands
  task automatic read_byte(input logic [4:0] addr, output logic [7:0] data);
    @(negedge clk_sys);
    host_req = '{cs: 1'b1, rd: 1'b1, addr: addr};
    @(negedge clk_sys);
    // released address lines do not keep their last value
    host_req = '{cs: 1'b0, rd: 1'b0, addr: ~addr};
    @(negedge clk_sys);
    data = host_rdata;
  endtask
endmodule

//--- verif/ers_status_bank_bench.sv
// ers_status_bank_bench: self-checking bench of the e1 receive status page
// assumes: reads go through ers_host_model; framer inputs change on the falling edge
`timescale 1ns/100ps

module ers_status_bank_bench;
  // a short millisecond keeps every persistence count inside the run
  localparam int          CPM     = 10;
  localparam int          HALF_NS = 500 * CPM * 10;
  localparam logic [63:0] EXT     = 64'h1357_9bdf_2468_ace0;
  localparam logic [4:0]  SYN     = ers_pkg::OFS_SYNC_STATUS;
  localparam logic [4:0]  TMR     = ers_pkg::OFS_TIMER_STATUS;

  logic                   clk_sys;
  logic                   rst_n;
  logic                   basic_align_loss, multiframe_align_loss, crc_multiframe_align_loss;
  logic                   multiframe_end, rx_ebit_one, rx_ebit_two, crc_interwork_in;
  logic                   maint_option, auto_interwork, fas_strobe, crc_sync_pulse;
  logic                   nonnormal_frames, terminal_frame_sync, ais_status;
  logic [7:0]             fas_byte;
  logic [7:0]             host_rdata;
  logic                   force_reframe;
  ers_pkg::ers_host_req_t host_req;
  int                     bad_count;
  int                     samples_checked;

  ers_status_bank #(.CYCLES_PER_MS(CPM)) ers_status_bank_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .basic_align_loss(basic_align_loss),
    .multiframe_align_loss(multiframe_align_loss),
    .crc_multiframe_align_loss(crc_multiframe_align_loss), .multiframe_end(multiframe_end),
    .rx_ebit_one(rx_ebit_one), .rx_ebit_two(rx_ebit_two), .crc_interwork_in(crc_interwork_in),
    .maint_option(maint_option), .auto_interwork(auto_interwork), .fas_strobe(fas_strobe),
    .fas_byte(fas_byte), .crc_sync_pulse(crc_sync_pulse), .nonnormal_frames(nonnormal_frames),
    .terminal_frame_sync(terminal_frame_sync), .ais_status(ais_status), .ext_status(EXT),
    .host_req(host_req), .host_rdata(host_rdata), .force_reframe(force_reframe));

  ers_host_model ers_host_model_i (
    .clk_sys(clk_sys), .host_req(host_req), .host_rdata(host_rdata));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // shared checking helpers
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_word(input logic [4:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    ers_host_model_i.read_byte(a, d);
    chk(what, exp, d);
  endtask

  task automatic rd_bit(input logic [4:0] a, input int b, input logic e, input string what);
    logic [7:0] d;
    ers_host_model_i.read_byte(a, d);
    chk(what, {7'h00, e}, {7'h00, d[b]});
  endtask

  task automatic wait_ms(input int n);
    repeat (n * CPM) @(negedge clk_sys);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  // timer word read first: the ms tick moves after ten clocks
  task automatic t_map();
    logic [4:0] gaps [4] = '{5'h00, 5'h0f, 5'h1b, 5'h1e};
    rd_word(TMR, 8'h00, "timer rst");
    rd_word(SYN, 8'h80, "sync rst");
    rd_word(5'h11, 8'h00, "fas rst");
    rd_word(ers_pkg::OFS_PART_ID, ers_pkg::PART_ID_VALUE, "id");
    foreach (gaps[i]) rd_word(gaps[i], 8'h00, "unused");
    for (int k = 0; k < 8; k++) rd_word(5'h13 + 5'(k), EXT[63 - 8 * k -: 8], "ext");
  endtask

  // crc loss only with basic loss, so no reframe can build up here
  task automatic t_sync();
    logic [3:0] v;
    for (int i = 0; i < 16; i++)
    begin
      v = 4'(i);
      @(negedge clk_sys);
      basic_align_loss = v[3];
      multiframe_align_loss = v[2];
      crc_multiframe_align_loss = v[1] & v[3];
      crc_interwork_in = v[0];
      rd_word(SYN, {v[3], v[2], v[1] & v[3], 4'h0, v[0]}, "sync live");
    end
  endtask

  task automatic t_ebit(input logic a, input logic b);
    @(negedge clk_sys);
    multiframe_end = 1'b1;
    rx_ebit_one = a;
    rx_ebit_two = b;
    @(negedge clk_sys);
    multiframe_end = 1'b0;
    rx_ebit_one = ~a;
    rx_ebit_two = ~b;
    rd_bit(SYN, 4, a, "ebit1");
    rd_bit(SYN, 3, b, "ebit2");
  endtask

  task automatic t_fas(input logic [7:0] v);
    @(negedge clk_sys);
    fas_strobe = 1'b1;
    fas_byte = v;
    @(negedge clk_sys);
    fas_strobe = 1'b0;
    fas_byte = ~v;
    rd_word(5'h11, v, "fas");
  endtask

  // red alarm (ka=0) or keep-alive (ka=1): set after 100 ms of cause, clear at once
  task automatic t_hold(input logic ka);
    logic [4:0] a;
    int b;
    a = ka ? TMR : SYN;
    b = ka ? 0 : 1;
    @(negedge clk_sys);
    basic_align_loss = 1'b0;
    @(negedge clk_sys);
    basic_align_loss = ~ka;
    ais_status = ka;
    wait_ms(97);
    rd_bit(a, b, 1'b0, "alarm early");
    wait_ms(4);
    rd_bit(a, b, 1'b1, "alarm set");
    @(negedge clk_sys);
    basic_align_loss = 1'b0;
    ais_status = 1'b0;
    rd_bit(a, b, 1'b0, "alarm clr");
  endtask

  task automatic t_tmr();
    logic [7:0] w0;
    @(negedge clk_sys);
    basic_align_loss = 1'b1;
    crc_multiframe_align_loss = 1'b1;
    maint_option = 1'b1;
    auto_interwork = 1'b0;
    @(negedge clk_sys);
    basic_align_loss = 1'b0;
    ers_host_model_i.read_byte(TMR, w0);
    wait_ms(6);
    rd_bit(SYN, 2, 1'b0, "reframe early");
    rd_bit(TMR, 2, w0[2], "8ms early");
    wait_ms(4);
    rd_bit(SYN, 2, 1'b1, "reframe");
    rd_bit(TMR, 2, ~w0[2], "8ms expiry");
    chk("force on", 8'h01, {7'h00, force_reframe});
    @(negedge clk_sys);
    auto_interwork = 1'b1;
    @(negedge clk_sys);
    chk("force off", 8'h00, {7'h00, force_reframe});
    crc_multiframe_align_loss = 1'b0;
    rd_bit(SYN, 2, 1'b0, "reframe clr");
    wait_ms(385);
    rd_bit(TMR, 3, w0[3], "400ms early");
    wait_ms(5);
    rd_bit(TMR, 3, ~w0[3], "400ms expiry");
  endtask

  task automatic t_pers();
    @(negedge clk_sys);
    terminal_frame_sync = 1'b1;
    wait_ms(8);
    rd_bit(TMR, 4, 1'b0, "lock early");
    wait_ms(4);
    rd_bit(TMR, 4, 1'b1, "lock");
    @(negedge clk_sys);
    terminal_frame_sync = 1'b0;
    nonnormal_frames = 1'b1;
    rd_bit(TMR, 4, 1'b0, "lock clr");
    wait_ms(96);
    rd_bit(TMR, 5, 1'b0, "nonnormal early");
    wait_ms(5);
    rd_bit(TMR, 5, 1'b1, "nonnormal");
    @(negedge clk_sys);
    nonnormal_frames = 1'b0;
    terminal_frame_sync = 1'b1;
    wait_ms(12);
    rd_bit(TMR, 5, 1'b0, "nonnormal clr");
  endtask

  // samples sit midway between expected toggles, so a phase slip shows
  task automatic t_tick();
    logic [7:0] w0, w1;
    @(negedge clk_sys);
    crc_sync_pulse = 1'b1;
    @(negedge clk_sys);
    crc_sync_pulse = 1'b0;
    ers_host_model_i.read_byte(TMR, w0);
    for (int k = 0; k < 4; k++)
    begin
      repeat (k == 0 ? 10 : 7) @(negedge clk_sys);
      ers_host_model_i.read_byte(TMR, w1);
      chk("ms tick", {7'h00, w0[1] ^ ((k + 1) % 2 == 1)}, {7'h00, w1[1]});
    end
  endtask

  task automatic t_sec();
    logic [7:0] w0, w1, w2;
    longint tp, dt;
    tp = 0;
    ers_host_model_i.read_byte(TMR, w0);
    for (int p = 0; p < 3; p++)
    begin
      w1 = w0;
      for (int n = 0; n < 2000 && w1[7] === w0[7]; n++)
        ers_host_model_i.read_byte(TMR, w1);
      dt = $time - tp;
      tp = $time;
      ers_host_model_i.read_byte(TMR, w2);
      chk("one sec", {7'h00, w0[6] ^ ~w1[7]}, {7'h00, w2[6]});
      if (p > 0)
        chk("half period", 8'h01, {7'h00, dt > HALF_NS - 40 && dt < HALF_NS + 40});
      w0 = w2;
    end
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    bad_count = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    basic_align_loss = 1'b1;
    multiframe_align_loss = 1'b0;
    crc_multiframe_align_loss = 1'b0;
    multiframe_end = 1'b0;
    rx_ebit_one = 1'b0;
    rx_ebit_two = 1'b0;
    crc_interwork_in = 1'b0;
    maint_option = 1'b0;
    auto_interwork = 1'b0;
    fas_strobe = 1'b0;
    fas_byte = 8'h00;
    crc_sync_pulse = 1'b0;
    nonnormal_frames = 1'b0;
    terminal_frame_sync = 1'b0;
    ais_status = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    t_map();
    t_sync();
    t_ebit(1'b1, 1'b0);
    t_ebit(1'b0, 1'b1);
    t_fas(8'h9b);
    t_fas(ers_pkg::FAS_GOOD_PATTERN);
    t_hold(1'b0);
    t_hold(1'b1);
    t_tmr();
    t_pers();
    t_tick();
    t_sec();
    close_out();
  end

  // the whole run needs about 20000 clocks
  initial
  begin
    repeat (80000) @(posedge clk_sys);
    bad_count++;
    close_out();
  end
endmodule
